// >>> design/nvsram_spi_pkg.sv
// Constants shared by the serial memory command block.
// Assumes a byte-wide status register and a 13-bit byte address space.
package nvsram_spi_pkg;

    // Command opcodes
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH = 8'h04;
    localparam logic [7:0] OP_STATUS_WR = 8'h01;
    localparam logic [7:0] OP_STATUS_RD = 8'h05;
    localparam logic [7:0] OP_ARRAY_RD = 8'h03;

    // Status register field positions
    localparam int BIT_RESERVED = 7;
    localparam int BIT_SAVE_DISABLE = 6;
    localparam int BIT_ROLLOVER = 5;
    localparam int BIT_SECURE_FAIL = 4;
    localparam int BIT_PROTECT_HIGH = 3;
    localparam int BIT_PROTECT_LOW = 2;
    localparam int BIT_WRITE_LATCH = 1;
    localparam int BIT_READY_BUSY = 0;

    // Bits a status write may change
    localparam logic [7:0] STATUS_WRITE_MASK = 8'hEC;
    // Nonvolatile bits copied by a save
    localparam logic [7:0] STATUS_NV_MASK = 8'h6C;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Array geometry
    localparam int ARRAY_ADDR_BITS = 13;

    typedef enum logic [2:0] {
        ST_CMD = 3'b000,
        ST_ADDR = 3'b001,
        ST_STATUS_WRITE_CMD = 3'b010,
        ST_STATUS_READ_CMD = 3'b011,
        ST_READ = 3'b100,
        ST_IGNORE = 3'b101
    } spi_state_type;

    typedef enum logic [1:0] {
        ACT_NONE = 2'b00,
        ACT_SET = 2'b01,
        ACT_CLR = 2'b10,
        ACT_STATUS_WRITE_CMD = 2'b11
    } action_type;

endpackage

// >>> design/spi_nvsram_status_write_latch_read.sv
// Command logic of a serial memory slave: write latch, status register, array read.
// Assumes the master keeps chip select high for several clk periods between frames,
// and an external array answers mem_addr with mem_rdata combinationally in the sck domain.
//
// Summary of operation
// - Set-latch opcode sets the write latch at deselect.
// - Write latch is zero after reset.
// - Completed status or array write clears the write latch.
// - A write to a protected location clears the write latch.
// - Deselect during pause clears the write latch and aborts.
// - Clear-latch opcode clears the write latch.
// - Eight-bit status: reserved bit 7, latch bit 1, busy bit 0.
// - Bit 6 set disables the power-loss save; zero is default.
// - Bit 5 selects page wrap (zero) or continuous writes (one).
// - Read-only bit 4 flags a failed secure write.
// - Bits 3-2 choose the protected array region.
// - Bit 0 shows busy; only status read runs while busy.
// - Status-read opcode shifts the status byte out.
// - Continued status read re-samples status every eight bits.
// - Status write changes only the writable bits.
// - No busy delay after a status write.
// - Nonvolatile copy of status is taken only on a save.
// - Array read: opcode, 16-bit address, data out MSB first.
// - After the address, serial input is ignored until deselect.
// - Read address increments, wrapping at the array end.
// - Host may end a read at any time by deselecting.
// - Everything MSB first; command framed by chip select.
// - Sample input on rising sck, drive output on falling sck.
// - Status write opcode takes one data byte and no address.
`timescale 1ns/1ps
`default_nettype none

module spi_nvsram_status_write_latch_read
    import nvsram_spi_pkg::*;
(
    // System clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Serial link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    output logic so,
    output logic so_oe,
    // Array read port, sck domain
    output logic [nvsram_spi_pkg::ARRAY_ADDR_BITS-1:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    // Events from store, recall, write and secure engines, clk domain
    input wire logic nv_busy,
    input wire logic save_pulse,
    input wire logic restore_pulse,
    input wire logic array_write_done,
    input wire logic protected_write_hit,
    input wire logic secure_write_start,
    input wire logic secure_write_fail,
    // Status view
    output logic [7:0] status_control,
    output logic [7:0] nv_shadow
);
    import nvsram_spi_pkg::*;

    // System clock domain state
    logic cs_m_q;
    logic cs_s_q;
    logic cs_d_q;
    logic hold_pin_m_q;
    logic hold_pin_s_q;
    logic nv_busy_m_q;
    logic nv_busy_q;

    // Status fields, one flop each so every field has a single writer
    logic reserved_q;
    logic power_loss_save_disable_q;
    logic page_rollover_select_q;
    logic secure_write_fail_flag_q;
    logic [1:0] protect_level_field_q;
    logic write_enable_latch_q;
    logic ready_busy_flag_q;
    logic [7:0] status_q;
    logic [7:0] shadow_q;
    logic frame_end;

    // Link clock domain
    spi_state_type state_q;
    logic [2:0] bit_q;
    logic [6:0] shift_q;
    logic addr_byte_q;
    logic [ARRAY_ADDR_BITS-9:0] addr_hi_q;
    logic [ARRAY_ADDR_BITS-1:0] mem_addr_q;
    action_type act_q;
    logic [7:0] wr_data_q;
    logic busy_m_q;
    logic busy_s_q;
    logic [7:0] stat_m_q;
    logic [7:0] stat_s_q;
    logic hold_m_q;
    logic hold_s_q;
    logic [7:0] out_q;
    logic so_q;
    logic so_oe_q;
    logic [7:0] rx_byte;
    logic byte_done;
    logic out_active;
    logic [7:0] out_src;

    assign rx_byte = {shift_q, si};
    assign byte_done = (bit_q == 3'h7) && !hold_s_q;
    assign out_active = (state_q == ST_STATUS_READ_CMD) || (state_q == ST_READ);
    assign out_src = (state_q == ST_STATUS_READ_CMD) ? stat_s_q : mem_rdata;

    // Busy and status snapshot cross into sck through two flops on rising sck, inside frames too
    always_ff @(posedge sck)
    begin
        busy_m_q <= nv_busy_q;
        busy_s_q <= busy_m_q;
        stat_m_q <= status_q;
        stat_s_q <= stat_m_q;
    end

    // Pause pin is caught while sck is low
    always_ff @(negedge sck or posedge cs_n)
    begin
        if (cs_n)
        begin
            hold_m_q <= 1'b0;
            hold_s_q <= 1'b0;
        end
        else
        begin
            hold_m_q <= !hold_n;
            hold_s_q <= hold_m_q;
        end
    end

    // Bit framing restarts with every selection
    always_ff @(posedge sck or posedge cs_n)
    begin
        if (cs_n)
        begin
            bit_q <= 3'h0;
            shift_q <= 7'h00;
        end
        else if (!hold_s_q)
        begin
            bit_q <= bit_q + 3'h1;
            shift_q <= rx_byte[6:0];
        end
    end

    always_ff @(posedge sck or posedge cs_n)
    begin
        if (cs_n)
        begin
            state_q <= ST_CMD;
            addr_byte_q <= 1'b0;
        end
        else if (byte_done)
        begin
            unique case (state_q)
                ST_CMD:
                begin
                    if (busy_s_q && rx_byte != OP_STATUS_RD)
                        state_q <= ST_IGNORE;
                    else if (rx_byte == OP_STATUS_RD)
                        state_q <= ST_STATUS_READ_CMD;
                    else if (rx_byte == OP_STATUS_WR)
                        state_q <= ST_STATUS_WRITE_CMD;
                    else if (rx_byte == OP_ARRAY_RD)
                        state_q <= ST_ADDR;
                    else
                        state_q <= ST_IGNORE;
                end
                ST_ADDR:
                begin
                    addr_byte_q <= 1'b1;
                    if (addr_byte_q)
                        state_q <= ST_READ;
                end
                ST_STATUS_WRITE_CMD: state_q <= ST_IGNORE;
                ST_STATUS_READ_CMD: state_q <= ST_STATUS_READ_CMD;
                ST_READ: state_q <= ST_READ;
                ST_IGNORE: state_q <= ST_IGNORE;
                default: state_q <= ST_IGNORE;
            endcase
        end
    end

    // Action and data wait for deselect; they are held while sck is still
    always_ff @(posedge sck)
    begin
        if (state_q == ST_CMD && bit_q == 3'h0)
            act_q <= ACT_NONE;
        if (byte_done && state_q == ST_CMD && !busy_s_q)
        begin
            if (rx_byte == OP_SET_LATCH)
                act_q <= ACT_SET;
            else if (rx_byte == OP_CLR_LATCH)
                act_q <= ACT_CLR;
        end
        if (byte_done && state_q == ST_STATUS_WRITE_CMD)
        begin
            act_q <= ACT_STATUS_WRITE_CMD;
            wr_data_q <= rx_byte;
        end
    end

    // Read address, upper address bits dropped
    always_ff @(posedge sck)
    begin
        if (byte_done && state_q == ST_ADDR)
        begin
            if (!addr_byte_q)
                addr_hi_q <= rx_byte[ARRAY_ADDR_BITS-9:0];
            else
                mem_addr_q <= {addr_hi_q, rx_byte};
        end
        else if (byte_done && state_q == ST_READ)
            mem_addr_q <= mem_addr_q + 13'h0001;
    end

    // Output shifts on falling sck; each new byte re-samples its source
    always_ff @(negedge sck or posedge cs_n)
    begin
        if (cs_n)
        begin
            so_q <= 1'b0;
            so_oe_q <= 1'b0;
            out_q <= 8'h00;
        end
        else
        begin
            // Pause is read through its second flop only
            so_oe_q <= out_active && !hold_s_q;
            if (out_active && !hold_s_q)
            begin
                if (bit_q == 3'h0)
                begin
                    out_q <= out_src;
                    so_q <= out_src[7];
                end
                else
                    so_q <= out_q[3'h7 - bit_q];
            end
        end
    end

    assign so = so_q;
    assign so_oe = so_oe_q;
    assign mem_addr = mem_addr_q;

    // System clock domain
    // Frame end follows the chip select rise by two to three clk edges
    assign frame_end = cs_s_q && !cs_d_q;

    // Register image, one flop per field
    assign status_q = {
        reserved_q,
        power_loss_save_disable_q,
        page_rollover_select_q,
        secure_write_fail_flag_q,
        protect_level_field_q,
        write_enable_latch_q,
        ready_busy_flag_q
    };

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            cs_m_q <= 1'b1;
            cs_s_q <= 1'b1;
            cs_d_q <= 1'b1;
            hold_pin_m_q <= 1'b1;
            hold_pin_s_q <= 1'b1;
            nv_busy_m_q <= 1'b0;
            nv_busy_q <= 1'b0;
        end
        else
        begin
            cs_m_q <= cs_n;
            cs_s_q <= cs_m_q;
            cs_d_q <= cs_s_q;
            hold_pin_m_q <= hold_n;
            hold_pin_s_q <= hold_pin_m_q;
            nv_busy_m_q <= nv_busy;
            nv_busy_q <= nv_busy_m_q;
        end
    end

    // Write latch; a set at deselect wins over a same-cycle clear event
    always_ff @(posedge clk)
    begin
        if (!rstn)
            write_enable_latch_q <= STATUS_RESET[BIT_WRITE_LATCH];
        else if (frame_end && hold_pin_s_q && act_q == ACT_SET)
            write_enable_latch_q <= 1'b1;
        else if (frame_end && !hold_pin_s_q)
            write_enable_latch_q <= 1'b0;
        else if (frame_end && act_q == ACT_CLR)
            write_enable_latch_q <= 1'b0;
        else if (frame_end && act_q == ACT_STATUS_WRITE_CMD && write_enable_latch_q)
            write_enable_latch_q <= 1'b0;
        else if (array_write_done)
            write_enable_latch_q <= 1'b0;
        else if (protected_write_hit)
            write_enable_latch_q <= 1'b0;
    end

    // Writable fields; applied at once, no busy period follows
    // Reserved bit is stored as written; keeping it zero is up to the host
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            reserved_q <= STATUS_RESET[BIT_RESERVED];
            power_loss_save_disable_q <= STATUS_RESET[BIT_SAVE_DISABLE];
            page_rollover_select_q <= STATUS_RESET[BIT_ROLLOVER];
            protect_level_field_q <= STATUS_RESET[BIT_PROTECT_HIGH:BIT_PROTECT_LOW];
        end
        else if (frame_end && hold_pin_s_q && act_q == ACT_STATUS_WRITE_CMD
                 && write_enable_latch_q)
        begin
            reserved_q <= wr_data_q[BIT_RESERVED];
            power_loss_save_disable_q <= wr_data_q[BIT_SAVE_DISABLE];
            page_rollover_select_q <= wr_data_q[BIT_ROLLOVER];
            protect_level_field_q <= wr_data_q[BIT_PROTECT_HIGH:BIT_PROTECT_LOW];
        end
        else if (restore_pulse)
        begin
            // Restore brings back the saved nonvolatile fields
            reserved_q <= shadow_q[BIT_RESERVED];
            power_loss_save_disable_q <= shadow_q[BIT_SAVE_DISABLE];
            page_rollover_select_q <= shadow_q[BIT_ROLLOVER];
            protect_level_field_q <= shadow_q[BIT_PROTECT_HIGH:BIT_PROTECT_LOW];
        end
    end

    // Secure failure flag: a failure in the same cycle as a new start wins
    always_ff @(posedge clk)
    begin
        if (!rstn)
            secure_write_fail_flag_q <= STATUS_RESET[BIT_SECURE_FAIL];
        else if (secure_write_fail)
            secure_write_fail_flag_q <= 1'b1;
        else if (secure_write_start)
            secure_write_fail_flag_q <= 1'b0;
    end

    // Busy mirrors the synchronised store and recall level
    always_ff @(posedge clk)
    begin
        if (!rstn)
            ready_busy_flag_q <= STATUS_RESET[BIT_READY_BUSY];
        else
            ready_busy_flag_q <= nv_busy_q;
    end

    // Nonvolatile copy follows the register only on a save
    always_ff @(posedge clk)
    begin
        if (!rstn)
            shadow_q <= STATUS_RESET;
        else if (save_pulse)
            shadow_q <= status_q & STATUS_NV_MASK;
    end

    assign status_control = status_q;
    assign nv_shadow = shadow_q;

endmodule // spi_nvsram_status_write_latch_read

`default_nettype wire

// >>> dv/spi_nvsram_monitor.sv
// Assertions on the serial memory command block, system clock domain.
// Assumes chip select stays high for six or more clk cycles between frames.
`timescale 1ns/1ps
`default_nettype none
module spi_nvsram_monitor
    import nvsram_spi_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Link
    input wire logic cs_n,
    input wire logic so_oe,
    // Events
    input wire logic nv_busy,
    input wire logic save_pulse,
    input wire logic restore_pulse,
    input wire logic array_write_done,
    input wire logic protected_write_hit,
    input wire logic secure_write_fail,
    // Status
    input wire logic [7:0] status_control,
    input wire logic [7:0] nv_shadow
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rstn);
    a_save_copies_shadow: assert property (save_pulse |=>
        nv_shadow == ($past(status_control) & STATUS_NV_MASK)) else $error("save missed");
    a_shadow_holds_still: assert property (!save_pulse |=> $stable(nv_shadow))
        else $error("shadow moved without save");
    a_restore_loads_bits: assert property (restore_pulse |=>
        (status_control & 8'hEC) == ($past(nv_shadow) & 8'hEC)) else $error("restore missed");
    a_fail_flag_sets: assert property (secure_write_fail |=>
        status_control[BIT_SECURE_FAIL]) else $error("fail flag not set");
    // Only with chip select long idle, since a deselect set wins over a clear
    a_write_event_clears: assert property ((array_write_done || protected_write_hit) &&
        cs_n && $past(cs_n, 6) |=> !status_control[BIT_WRITE_LATCH]) else $error("latch kept");
    a_busy_flag_shown: assert property ($rose(nv_busy) |-> ##[1:4]
        status_control[BIT_READY_BUSY]) else $error("busy not shown");
    a_out_idle_deselect: assert property (cs_n && $past(cs_n) |-> !so_oe)
        else $error("serial out driven while deselected");
    a_latch_after_frame: assert property ($rose(status_control[BIT_WRITE_LATCH]) |->
        cs_n && $past(cs_n, 2)) else $error("latch set inside a frame");
    c_save: cover property (save_pulse);
    c_restore: cover property (restore_pulse);
    c_latch_set: cover property ($rose(status_control[BIT_WRITE_LATCH]));
endmodule // spi_nvsram_monitor

bind spi_nvsram_status_write_latch_read spi_nvsram_monitor mon (.clk, .rstn, .cs_n, .so_oe,
    .nv_busy, .save_pulse, .restore_pulse, .array_write_done, .protected_write_hit,
    .secure_write_fail, .status_control, .nv_shadow);
`default_nettype wire

// >>> dv/spi_host_model.sv
// Behavioural SPI master for mode 0 or 3, 12 ns serial clock inside frames only.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
(
    // Serial link
    output logic sck,
    output logic cs_n,
    output logic si,
    output logic hold_n,
    input wire logic so
);
    logic cpol = 1'h0;
    logic slow = 1'h0;
    initial
    begin
        sck = 1'h0;
        cs_n = 1'h1;
        si = 1'h0;
        hold_n = 1'h1;
    end
    // Released input keeps moving so a stale level never passes for data
    always #7 if (cs_n) si = ~si;
    task automatic sel();
        sck = cpol;
        #5;
        cs_n = 1'h0;
        #6;
    endtask
    task automatic desel();
        #6;
        sck = cpol;
        #6;
        cs_n = 1'h1;
        #6;
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            sck = 1'h0;
            si = tx[i];
            #6;
            rx[i] = so;
            sck = 1'h1;
            #6;
        end
        // Slow mode keeps the 12 ns clock but stalls between bytes
        if (slow)
            #30;
    endtask
    // Pause taken on low clock phases, then deselect while still paused
    task automatic hold_abort();
        sck = 1'h0;
        #3;
        hold_n = 1'h0;
        repeat (3)
        begin
            #6 sck = 1'h1;
            #6 sck = 1'h0;
        end
        cs_n = 1'h1;
        #20 hold_n = 1'h1;
    endtask
endmodule // spi_host_model
`default_nettype wire

// >>> dv/spi_nvsram_status_write_latch_read_tb_top.sv
// Self-checking bench for the serial memory command block.
// Link driven by the host model; event pins driven on clk by this module.
`timescale 1ns/1ps
`default_nettype none
module spi_nvsram_status_write_latch_read_tb_top;
    import nvsram_spi_pkg::*;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic nv_busy = 1'h0;
    logic [5:0] ev = 6'h0;
    logic sck, cs_n, si, hold_n, so, so_oe, so_line;
    logic [12:0] mem_addr, a;
    logic [7:0] mem_rdata, status_control, nv_shadow, rx;
    int n_fail = 0;
    int n_checks = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    assign mem_rdata = {mem_addr[4:0], mem_addr[12:10]} ^ 8'h5A;
    // Undriven serial output floats to its pull-up, so reads depend on the enable
    assign so_line = so_oe ? so : 1'h1;
    spi_nvsram_status_write_latch_read DUT (
        .clk, .rstn, .sck, .cs_n, .si, .hold_n, .so, .so_oe, .mem_addr, .mem_rdata,
        .nv_busy, .save_pulse(ev[0]), .restore_pulse(ev[1]), .array_write_done(ev[2]),
        .protected_write_hit(ev[3]), .secure_write_start(ev[4]), .secure_write_fail(ev[5]),
        .status_control, .nv_shadow);
    spi_host_model host (.sck, .cs_n, .si, .hold_n, .so(so_line));
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic frame(input logic [7:0] op, input int n, input logic [7:0] v);
        host.sel();
        host.xfer(op, rx);
        if (n > 1)
            host.xfer(v, rx);
        host.desel();
        #100;
    endtask
    task automatic pulse(input int k);
        @(posedge clk) ev[k] <= 1'h1;
        @(posedge clk) ev[k] <= 1'h0;
        repeat (3) @(posedge clk);
    endtask
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_fail++;
            close_out();
        end
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rstn <= 1'h1;
        repeat (8) @(posedge clk);
        chk(status_control, 8'h00, "status after reset");
        frame(OP_STATUS_RD, 2, 8'hFF);
        chk(rx, 8'h00, "status read");
        frame(OP_STATUS_WR, 2, 8'h6C);
        chk(status_control, 8'h00, "write without latch");
        frame(OP_SET_LATCH, 1, 8'h00);
        chk(status_control, 8'h02, "latch set");
        frame(OP_CLR_LATCH, 1, 8'h00);
        chk(status_control, 8'h00, "latch cleared");
        $display("test latch done");
        for (int k = 0; k < 4; k++)
        begin
            host.cpol = k[0];
            host.slow = k[1];
            frame(OP_SET_LATCH, 1, 8'h00);
            frame(OP_STATUS_WR, 2, {4'h7, k[1:0], 2'h3});
            frame(OP_STATUS_RD, 2, 8'hFF);
            chk(rx, {3'h3, 1'h0, k[1:0], 2'h0}, "status write");
        end
        host.cpol = 1'h0;
        pulse(0);
        chk(nv_shadow, 8'h6C, "shadow after save");
        frame(OP_SET_LATCH, 1, 8'h00);
        frame(OP_STATUS_WR, 2, 8'h00);
        chk(nv_shadow, 8'h6C, "shadow kept on write");
        pulse(1);
        chk(status_control, 8'h6C, "status restored");
        for (int k = 2; k < 4; k++)
        begin
            frame(OP_SET_LATCH, 1, 8'h00);
            pulse(k);
            chk(status_control, 8'h6C, "latch cleared by write event");
        end
        $display("test status done");
        pulse(5);
        frame(OP_STATUS_RD, 2, 8'hFF);
        chk(rx, 8'h7C, "secure fail flag");
        host.sel();
        host.xfer(OP_STATUS_RD, rx);
        host.xfer(8'hFF, rx);
        pulse(4);
        #100;
        host.xfer(8'hFF, rx);
        host.xfer(8'hFF, rx);
        host.desel();
        chk(rx, 8'h6C, "status re-sampled");
        frame(OP_SET_LATCH, 1, 8'h00);
        host.sel();
        host.xfer(OP_STATUS_RD, rx);
        host.hold_abort();
        #100;
        chk(status_control, 8'h6C, "latch after hold abort");
        $display("test flags done");
        @(posedge clk) nv_busy <= 1'h1;
        repeat (8) @(posedge clk);
        frame(OP_SET_LATCH, 1, 8'h00);
        frame(OP_STATUS_RD, 2, 8'hFF);
        chk(rx, 8'h6D, "busy shown, set refused");
        @(posedge clk) nv_busy <= 1'h0;
        repeat (8) @(posedge clk);
        host.cpol = 1'h1;
        host.sel();
        host.xfer(OP_ARRAY_RD, rx);
        host.xfer(8'hFF, rx);
        host.xfer(8'hFE, rx);
        for (int k = 0; k < 3; k++)
        begin
            host.xfer(OP_SET_LATCH, rx);
            a = 13'h1FFE + 13'(k);
            chk(rx, {a[4:0], a[12:10]} ^ 8'h5A, "array byte");
        end
        host.desel();
        #100;
        chk(status_control, 8'h6C, "input ignored in read");
        $display("test read done");
        close_out();
    end
endmodule // spi_nvsram_status_write_latch_read_tb_top
`default_nettype wire
